// ==== include/ace_pkg.sv ====
`default_nettype none
package ace_pkg;

	localparam int AXI_AW = 8;
	localparam int AXI_DW = 32;
	localparam int AXI_SW = 4;
	localparam int BYTE_W = 8;
	localparam int SRC_W  = 32;

	localparam logic [AXI_AW-1:0] ADDR_CFG       = 8'h00;
	localparam logic [AXI_AW-1:0] ADDR_ICMP_VAL  = 8'h04;
	localparam logic [AXI_AW-1:0] ADDR_SRC_ADDR  = 8'h08;
	localparam logic [AXI_AW-1:0] ADDR_SRC_MASK  = 8'h0C;
	localparam logic [AXI_AW-1:0] ADDR_STATUS    = 8'h10;
	localparam logic [AXI_AW-1:0] ADDR_HIT_COUNT = 8'h14;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam int CFG_NH_MODE_LSB  = 0;
	localparam int NH_MODE_W        = 3;
	localparam int CFG_NH_VALUE_LSB = 8;
	localparam int CFG_SRC_FILT_BIT = 16;
	localparam int CFG_HOP_MODE_LSB = 20;
	localparam int HOP_MODE_W       = 2;
	localparam int CFG_TYPE_FILT_BIT = 24;
	localparam int CFG_CODE_FILT_BIT = 25;
	localparam int ICMP_TYPE_LSB    = 0;
	localparam int ICMP_CODE_LSB    = 8;
	localparam int STATUS_HIT_BIT   = 0;

	localparam logic [AXI_DW-1:0] CFG_WMASK      = 32'h0331FF07;
	localparam logic [AXI_DW-1:0] ICMP_WMASK     = 32'h0000FFFF;
	localparam logic [AXI_DW-1:0] FULL_WMASK     = 32'hFFFFFFFF;
	localparam logic [AXI_DW-1:0] CFG_RESET      = 32'h00000000;
	localparam logic [AXI_DW-1:0] ICMP_RESET     = 32'h00000000;
	localparam logic [AXI_DW-1:0] SRC_ADDR_RESET = 32'h00000000;
	localparam logic [AXI_DW-1:0] SRC_MASK_RESET = 32'hFFFFFFFF;

	localparam logic [BYTE_W-1:0] NH_ICMPV6 = 8'h3A;
	localparam logic [BYTE_W-1:0] NH_UDP    = 8'h11;
	localparam logic [BYTE_W-1:0] NH_TCP    = 8'h06;

	typedef enum logic [NH_MODE_W-1:0] {
		NH_ANY      = 3'h0,
		NH_SPECIFIC = 3'h1,
		NH_ICMP     = 3'h2,
		NH_UDP_SEL  = 3'h3,
		NH_TCP_SEL  = 3'h4
	} nh_mode_t;

	typedef enum logic [HOP_MODE_W-1:0] {
		HOP_ANY     = 2'h0,
		HOP_ZERO    = 2'h1,
		HOP_NONZERO = 2'h2
	} hop_mode_t;

endpackage
`default_nettype wire

// ==== include/match_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface match_if;
	import ace_pkg::*;

	nh_mode_t          nh_mode;
	logic [BYTE_W-1:0] nh_value;
	logic              source_address_filter;
	logic [SRC_W-1:0]  src_addr;
	logic [SRC_W-1:0]  src_mask;
	hop_mode_t         hop_mode;
	logic              type_filter;
	logic [BYTE_W-1:0] type_value;
	logic              code_filter;
	logic [BYTE_W-1:0] code_value;
	logic              is_ipv6;
	logic [BYTE_W-1:0] next_header;
	logic [SRC_W-1:0]  source_v6_low;
	logic [BYTE_W-1:0] hop_limit;
	logic [BYTE_W-1:0] icmp_type;
	logic [BYTE_W-1:0] icmp_code;
	logic              udp_ok;
	logic              tcp_ok;
	logic              nh_ok;
	logic              src_ok;
	logic              hop_ok;
	logic              icmp_ok;
	logic              hit;

	modport ctl (output nh_mode, nh_value, source_address_filter, src_addr, src_mask, hop_mode,
		type_filter, type_value, code_filter, code_value, is_ipv6, next_header, source_v6_low,
		hop_limit, icmp_type, icmp_code, udp_ok, tcp_ok,
		input nh_ok, src_ok, hop_ok, icmp_ok, hit);
	modport eng (input nh_mode, nh_value, source_address_filter, src_addr, src_mask, hop_mode,
		type_filter, type_value, code_filter, code_value, is_ipv6, next_header, source_v6_low,
		hop_limit, icmp_type, icmp_code, udp_ok, tcp_ok,
		output nh_ok, src_ok, hop_ok, icmp_ok, hit);
endinterface
`default_nettype wire

// ==== logic/ace_field_matcher.sv ====
`timescale 1ns/1ps
`default_nettype none
module ace_field_matcher
(
	match_if.eng m
);
	import ace_pkg::*;

	function automatic logic field_ok(input logic specific, input logic [BYTE_W-1:0] seen,
		input logic [BYTE_W-1:0] want);
		return !specific || (seen == want);
	endfunction

	logic nh_eq;
	logic type_ok;
	logic code_ok;
	logic src_eq;

	assign nh_eq   = m.next_header == m.nh_value;
	assign type_ok = field_ok(m.type_filter, m.icmp_type, m.type_value);
	assign code_ok = field_ok(m.code_filter, m.icmp_code, m.code_value);
	assign m.icmp_ok = type_ok & code_ok;

	// both sides masked so zero mask bits never matter
	assign src_eq   = (m.source_v6_low & m.src_mask) == (m.src_addr & m.src_mask);
	assign m.src_ok = !m.source_address_filter || src_eq;

	// unused mode codes never match, safer than a silent wildcard
	assign m.nh_ok = (m.nh_mode == NH_ANY) ? 1'b1 :
		(m.nh_mode == NH_SPECIFIC) ? nh_eq :
		(m.nh_mode == NH_ICMP) ? ((m.next_header == NH_ICMPV6) & m.icmp_ok) :
		(m.nh_mode == NH_UDP_SEL) ? ((m.next_header == NH_UDP) & m.udp_ok) :
		(m.nh_mode == NH_TCP_SEL) ? ((m.next_header == NH_TCP) & m.tcp_ok) :
		1'b0;

	assign m.hop_ok = (m.hop_mode == HOP_ANY) ? 1'b1 :
		(m.hop_mode == HOP_ZERO) ? (m.hop_limit == '0) :
		(m.hop_mode == HOP_NONZERO) ? (m.hop_limit != '0) :
		1'b0;

	assign m.hit = m.is_ipv6 & m.nh_ok & m.src_ok & m.hop_ok;
endmodule
`default_nettype wire

// ==== logic/ipv6_icmp_entry_matcher.sv ====
`timescale 1ns/1ps
`default_nettype none
// Contract
// - next header filter any ignores the next header field.
// - next header specific requires equality with configured byte 0..255.
// - ICMP selection matches only ICMPv6 frames, then applies type and code.
// - UDP selection matches only UDP frames, then applies UDP conditions.
// - TCP selection matches only TCP frames, then applies TCP conditions.
// - source address filter any ignores the source address.
// - source address specific compares only low 32 source address bits.
// - both addresses masked before compare; zero mask bits are don't-care.
// - hop condition zero rejects frames with hop limit above zero.
// - hop condition non-zero lets frames with hop limit above zero match.
// - hop condition any accepts every hop limit.
// - ICMP type filter any ignores the ICMP type.
// - ICMP type specific requires equal ICMP type byte.
// - ICMP code filter any ignores the ICMP code.
// - ICMP code specific requires equal ICMP code byte.
module ipv6_icmp_entry_matcher
(
	input  wire logic                       core_clk,
	input  wire logic                       rst_n,
	input  wire logic                       ce,
	input  wire logic                       awvalid,
	output logic                            awready,
	input  wire logic [ace_pkg::AXI_AW-1:0] awaddr,
	input  wire logic                       wvalid,
	output logic                            wready,
	input  wire logic [ace_pkg::AXI_DW-1:0] wdata,
	input  wire logic [ace_pkg::AXI_SW-1:0] wstrb,
	output logic                            bvalid,
	input  wire logic                       bready,
	output logic [1:0]                      bresp,
	input  wire logic                       arvalid,
	output logic                            arready,
	input  wire logic [ace_pkg::AXI_AW-1:0] araddr,
	output logic                            rvalid,
	input  wire logic                       rready,
	output logic [ace_pkg::AXI_DW-1:0]      rdata,
	output logic [1:0]                      rresp,
	input  wire logic                       frm_valid,
	input  wire logic                       frm_is_ipv6,
	input  wire logic [ace_pkg::BYTE_W-1:0] frm_next_header,
	input  wire logic [ace_pkg::SRC_W-1:0]  frm_source_v6_low,
	input  wire logic [ace_pkg::BYTE_W-1:0] frm_hop_limit,
	input  wire logic [ace_pkg::BYTE_W-1:0] frm_icmp_type,
	input  wire logic [ace_pkg::BYTE_W-1:0] frm_icmp_code,
	input  wire logic                       udp_cond_ok,
	input  wire logic                       tcp_cond_ok,
	output logic                            hit_valid,
	output logic                            hit
);
	import ace_pkg::*;

	function automatic logic [AXI_DW-1:0] merge_word(input logic [AXI_DW-1:0] old_w,
		input logic [AXI_DW-1:0] new_w, input logic [AXI_SW-1:0] strb, input logic [AXI_DW-1:0] wmask);
		logic [AXI_DW-1:0] res;
		res = old_w;
		for (int i = 0; i < AXI_SW; i++)
		begin
			if (strb[i])
				res[BYTE_W*i +: BYTE_W] = new_w[BYTE_W*i +: BYTE_W];
		end
		return res & wmask;
	endfunction

	logic              aw_full_q;
	logic [AXI_AW-1:0] aw_addr_q;
	logic              w_full_q;
	logic [AXI_DW-1:0] w_data_q;
	logic [AXI_SW-1:0] w_strb_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;
	logic              rvalid_q;
	logic [AXI_DW-1:0] rdata_q;
	logic [1:0]        rresp_q;
	logic [AXI_DW-1:0] cfg_q;
	logic [AXI_DW-1:0] cfg_d;
	logic [AXI_DW-1:0] icmp_val_q;
	logic [AXI_DW-1:0] icmp_val_d;
	logic [AXI_DW-1:0] src_addr_q;
	logic [AXI_DW-1:0] src_addr_d;
	logic [AXI_DW-1:0] src_mask_q;
	logic [AXI_DW-1:0] src_mask_d;
	logic [AXI_DW-1:0] hit_count_q;
	logic              hit_q;
	logic              hit_valid_q;
	logic              aw_take;
	logic              w_take;
	logic              ar_take;
	logic              wr_fire;
	logic              wr_map;
	logic              rd_map;
	logic [AXI_DW-1:0] rd_word;
	logic [AXI_DW-1:0] status_word;
	logic              frm_take;

	match_if mif ();

	ace_field_matcher u_match
	(
		.m (mif.eng)
	);

	// write channel: address and data latched separately, either order
	assign awready = ce & ~aw_full_q & ~bvalid_q;
	assign wready  = ce & ~w_full_q & ~bvalid_q;
	assign aw_take = awvalid & awready;
	assign w_take  = wvalid & wready;
	assign wr_fire = ce & aw_full_q & w_full_q & ~bvalid_q;
	assign wr_map  = (aw_addr_q == ADDR_CFG) | (aw_addr_q == ADDR_ICMP_VAL) |
		(aw_addr_q == ADDR_SRC_ADDR) | (aw_addr_q == ADDR_SRC_MASK);
	assign bvalid  = bvalid_q;
	assign bresp   = bresp_q;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_full_q <= 1'b0;
			aw_addr_q <= '0;
			w_full_q  <= 1'b0;
			w_data_q  <= '0;
			w_strb_q  <= '0;
		end
		else if (ce)
		begin
			aw_full_q <= aw_take | (aw_full_q & ~wr_fire);
			w_full_q  <= w_take | (w_full_q & ~wr_fire);
			if (aw_take)
				aw_addr_q <= awaddr;
			if (w_take)
			begin
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end
		else if (ce)
		begin
			if (wr_fire)
			begin
				bvalid_q <= 1'b1;
				bresp_q  <= wr_map ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bready)
				bvalid_q <= 1'b0;
		end
	end

	// read channel: one outstanding read, data registered
	assign arready = ce & ~rvalid_q;
	assign ar_take = arvalid & arready;
	assign status_word = {{(AXI_DW-1){1'b0}}, hit_q} << STATUS_HIT_BIT;
	assign rd_map  = (araddr == ADDR_CFG) | (araddr == ADDR_ICMP_VAL) | (araddr == ADDR_SRC_ADDR) |
		(araddr == ADDR_SRC_MASK) | (araddr == ADDR_STATUS) | (araddr == ADDR_HIT_COUNT);
	assign rd_word = (araddr == ADDR_CFG) ? cfg_q :
		(araddr == ADDR_ICMP_VAL) ? icmp_val_q :
		(araddr == ADDR_SRC_ADDR) ? src_addr_q :
		(araddr == ADDR_SRC_MASK) ? src_mask_q :
		(araddr == ADDR_STATUS) ? status_word :
		(araddr == ADDR_HIT_COUNT) ? hit_count_q : '0;
	assign rvalid = rvalid_q;
	assign rdata  = rdata_q;
	assign rresp  = rresp_q;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rvalid_q <= 1'b0;
			rdata_q  <= '0;
			rresp_q  <= RESP_OKAY;
		end
		else if (ce)
		begin
			if (ar_take)
			begin
				rvalid_q <= 1'b1;
				rdata_q  <= rd_word;
				rresp_q  <= rd_map ? RESP_OKAY : RESP_SLVERR;
			end
			else if (rready)
				rvalid_q <= 1'b0;
		end
	end

	// configuration registers, reserved bits held at zero
	assign cfg_d      = (wr_fire && aw_addr_q == ADDR_CFG) ?
		merge_word(cfg_q, w_data_q, w_strb_q, CFG_WMASK) : cfg_q;
	assign icmp_val_d = (wr_fire && aw_addr_q == ADDR_ICMP_VAL) ?
		merge_word(icmp_val_q, w_data_q, w_strb_q, ICMP_WMASK) : icmp_val_q;
	assign src_addr_d = (wr_fire && aw_addr_q == ADDR_SRC_ADDR) ?
		merge_word(src_addr_q, w_data_q, w_strb_q, FULL_WMASK) : src_addr_q;
	assign src_mask_d = (wr_fire && aw_addr_q == ADDR_SRC_MASK) ?
		merge_word(src_mask_q, w_data_q, w_strb_q, FULL_WMASK) : src_mask_q;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cfg_q      <= CFG_RESET;
			icmp_val_q <= ICMP_RESET;
			src_addr_q <= SRC_ADDR_RESET;
			src_mask_q <= SRC_MASK_RESET;
		end
		else if (ce)
		begin
			cfg_q      <= cfg_d;
			icmp_val_q <= icmp_val_d;
			src_addr_q <= src_addr_d;
			src_mask_q <= src_mask_d;
		end
	end

	// a write landing mid-frame takes effect from the next frame cycle on
	assign mif.nh_mode     = nh_mode_t'(cfg_q[CFG_NH_MODE_LSB +: NH_MODE_W]);
	assign mif.nh_value    = cfg_q[CFG_NH_VALUE_LSB +: BYTE_W];
	assign mif.source_address_filter = cfg_q[CFG_SRC_FILT_BIT];
	assign mif.src_addr    = src_addr_q;
	assign mif.src_mask    = src_mask_q;
	assign mif.hop_mode    = hop_mode_t'(cfg_q[CFG_HOP_MODE_LSB +: HOP_MODE_W]);
	assign mif.type_filter = cfg_q[CFG_TYPE_FILT_BIT];
	assign mif.type_value  = icmp_val_q[ICMP_TYPE_LSB +: BYTE_W];
	assign mif.code_filter = cfg_q[CFG_CODE_FILT_BIT];
	assign mif.code_value  = icmp_val_q[ICMP_CODE_LSB +: BYTE_W];
	assign mif.is_ipv6     = frm_is_ipv6;
	assign mif.next_header = frm_next_header;
	assign mif.source_v6_low = frm_source_v6_low;
	assign mif.hop_limit   = frm_hop_limit;
	assign mif.icmp_type   = frm_icmp_type;
	assign mif.icmp_code   = frm_icmp_code;
	assign mif.udp_ok      = udp_cond_ok;
	assign mif.tcp_ok      = tcp_cond_ok;

	// verdict registered one cycle after the frame strobe
	assign frm_take  = ce & frm_valid;
	assign hit_valid = hit_valid_q;
	assign hit       = hit_q;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hit_valid_q <= 1'b0;
			hit_q       <= 1'b0;
			hit_count_q <= '0;
		end
		else if (ce)
		begin
			hit_valid_q <= frm_valid;
			if (frm_valid)
				hit_q <= mif.hit;
			if (frm_valid && mif.hit)
				hit_count_q <= hit_count_q + 32'h00000001;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	property p_nh_any;
		mif.nh_mode == NH_ANY |-> mif.nh_ok;
	endproperty
	a_nh_any: assert property (p_nh_any) else $error("next header any did not pass");

	property p_nh_specific;
		frm_take && mif.nh_mode == NH_SPECIFIC && frm_next_header != mif.nh_value |=> !hit_q;
	endproperty
	a_nh_specific: assert property (p_nh_specific) else $error("next header mismatch hit");

	property p_nh_icmp;
		frm_take && mif.nh_mode == NH_ICMP && frm_next_header != NH_ICMPV6 |=> hit_valid_q && !hit_q;
	endproperty
	a_nh_icmp: assert property (p_nh_icmp) else $error("non icmp frame hit icmp entry");

	property p_nh_udp;
		frm_take && mif.nh_mode == NH_UDP_SEL && (frm_next_header != NH_UDP || !udp_cond_ok) |=> !hit_q;
	endproperty
	a_nh_udp: assert property (p_nh_udp) else $error("udp entry hit wrongly");

	property p_nh_tcp;
		frm_take && mif.nh_mode == NH_TCP_SEL && (frm_next_header != NH_TCP || !tcp_cond_ok) |=> !hit_q;
	endproperty
	a_nh_tcp: assert property (p_nh_tcp) else $error("tcp entry hit wrongly");

	property p_src_any;
		!mif.source_address_filter |-> mif.src_ok;
	endproperty
	a_src_any: assert property (p_src_any) else $error("source any did not pass");

	property p_src_low;
		mif.source_address_filter && src_mask_q == FULL_WMASK |-> mif.src_ok == (frm_source_v6_low == src_addr_q);
	endproperty
	a_src_low: assert property (p_src_low) else $error("low source compare wrong");

	property p_src_mask;
		mif.source_address_filter |->
			mif.src_ok == (((frm_source_v6_low ^ src_addr_q) & src_mask_q) == '0);
	endproperty
	a_src_mask: assert property (p_src_mask) else $error("masked source compare wrong");

	property p_hop_zero;
		frm_take && mif.hop_mode == HOP_ZERO && frm_hop_limit != '0 |=> hit_valid_q && !hit_q;
	endproperty
	a_hop_zero: assert property (p_hop_zero) else $error("hop zero let nonzero hop hit");

	property p_hop_nonzero;
		mif.hop_mode == HOP_NONZERO && frm_hop_limit != '0 |-> mif.hop_ok;
	endproperty
	a_hop_nonzero: assert property (p_hop_nonzero) else $error("nonzero hop refused");

	property p_hop_any;
		mif.hop_mode == HOP_ANY |-> mif.hop_ok;
	endproperty
	a_hop_any: assert property (p_hop_any) else $error("hop any refused");

	property p_type_any;
		!mif.type_filter && !mif.code_filter |-> mif.icmp_ok;
	endproperty
	a_type_any: assert property (p_type_any) else $error("icmp any refused");

	property p_type_spec;
		frm_take && mif.nh_mode == NH_ICMP && mif.type_filter && frm_icmp_type != mif.type_value |=> !hit_q;
	endproperty
	a_type_spec: assert property (p_type_spec) else $error("icmp type mismatch hit");

	property p_code_any;
		!mif.code_filter && mif.type_filter && frm_icmp_type == mif.type_value |-> mif.icmp_ok;
	endproperty
	a_code_any: assert property (p_code_any) else $error("icmp code any refused");

	property p_code_spec;
		frm_take && mif.nh_mode == NH_ICMP && mif.code_filter && frm_icmp_code != mif.code_value |=> !hit_q;
	endproperty
	a_code_spec: assert property (p_code_spec) else $error("icmp code mismatch hit");

	property p_and_all;
		frm_take |=> hit_q == ($past(frm_is_ipv6) && $past(mif.nh_ok) &&
			$past(mif.src_ok) && $past(mif.hop_ok));
	endproperty
	a_and_all: assert property (p_and_all) else $error("hit not the and of conditions");

	c_icmp_hit: cover property (frm_take && mif.nh_mode == NH_ICMP && mif.type_filter && mif.hit);
	c_masked_hit: cover property (frm_take && mif.source_address_filter && src_mask_q != FULL_WMASK && mif.hit);
	c_hop_reject: cover property (frm_take && mif.hop_mode == HOP_ZERO && frm_hop_limit != '0);
	c_wr_then_rd: cover property (wr_fire ##[1:4] ar_take);
endmodule
`default_nettype wire

// ==== dv/frame_parser_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module frame_parser_model
(
	input  wire logic                       core_clk,
	output logic                            frm_valid,
	output logic                            frm_is_ipv6,
	output logic [ace_pkg::BYTE_W-1:0]      frm_next_header,
	output logic [ace_pkg::SRC_W-1:0]       frm_source_v6_low,
	output logic [ace_pkg::BYTE_W-1:0]      frm_hop_limit,
	output logic [ace_pkg::BYTE_W-1:0]      frm_icmp_type,
	output logic [ace_pkg::BYTE_W-1:0]      frm_icmp_code,
	output logic                            udp_cond_ok,
	output logic                            tcp_cond_ok
);
	import ace_pkg::*;

	initial
	begin
		frm_valid = 1'b0;
		{frm_is_ipv6, frm_next_header, frm_source_v6_low, frm_hop_limit} = '0;
		{frm_icmp_type, frm_icmp_code, udp_cond_ok, tcp_cond_ok} = '0;
	end

	// one header per call; fields inverted between frames so stale values never look valid
	task automatic send(input logic is6, input logic [7:0] nh, input logic [31:0] s, input logic [7:0] hp,
		input logic [7:0] ty, input logic [7:0] co, input logic u, input logic t);
		frm_valid <= 1'b1;
		{frm_is_ipv6, frm_next_header, frm_source_v6_low, frm_hop_limit} <= {is6, nh, s, hp};
		{frm_icmp_type, frm_icmp_code, udp_cond_ok, tcp_cond_ok} <= {ty, co, u, t};
		@(posedge core_clk);
		frm_valid <= 1'b0;
		{frm_is_ipv6, frm_next_header, frm_source_v6_low, frm_hop_limit} <= ~{is6, nh, s, hp};
		{frm_icmp_type, frm_icmp_code, udp_cond_ok, tcp_cond_ok} <= ~{ty, co, u, t};
	endtask
endmodule
`default_nettype wire

// ==== dv/test_ipv6_icmp_entry_matcher.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_ipv6_icmp_entry_matcher;
	import ace_pkg::*;

	logic        core_clk = 1'b0;
	logic        rst_n    = 1'b0;
	logic        ce       = 1'b1;
	logic        awvalid  = 1'b0;
	logic [7:0]  awaddr   = 8'h00;
	logic        wvalid   = 1'b0;
	logic [31:0] wdata    = 32'h00000000;
	logic [3:0]  wstrb    = 4'h0;
	logic        bready   = 1'b0;
	logic        arvalid  = 1'b0;
	logic [7:0]  araddr   = 8'h00;
	logic        rready   = 1'b0;
	wire logic   awready, wready, bvalid, arready, rvalid, hit_valid, hit;
	wire logic   frm_valid, frm_is_ipv6, udp_cond_ok, tcp_cond_ok;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata, frm_source_v6_low;
	wire logic [7:0]  frm_next_header, frm_hop_limit, frm_icmp_type, frm_icmp_code;
	int          bad_count = 0;
	int          checked   = 0;
	int          hits      = 0;
	logic        last_hit  = 1'b0;
	logic [31:0] sa        = 32'h00000000;
	logic [31:0] sm        = 32'hFFFFFFFF;

	always #12.5 core_clk = ~core_clk;

	ipv6_icmp_entry_matcher dut_u (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
		.araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.frm_valid(frm_valid), .frm_is_ipv6(frm_is_ipv6), .frm_next_header(frm_next_header),
		.frm_source_v6_low(frm_source_v6_low), .frm_hop_limit(frm_hop_limit),
		.frm_icmp_type(frm_icmp_type), .frm_icmp_code(frm_icmp_code), .udp_cond_ok(udp_cond_ok),
		.tcp_cond_ok(tcp_cond_ok), .hit_valid(hit_valid), .hit(hit));

	frame_parser_model parser_u (.core_clk(core_clk), .frm_valid(frm_valid), .frm_is_ipv6(frm_is_ipv6),
		.frm_next_header(frm_next_header), .frm_source_v6_low(frm_source_v6_low),
		.frm_hop_limit(frm_hop_limit), .frm_icmp_type(frm_icmp_type), .frm_icmp_code(frm_icmp_code),
		.udp_cond_ok(udp_cond_ok), .tcp_cond_ok(tcp_cond_ok));

	task automatic fail(input string m);
		bad_count++;
		$display("BAD %0t %s", $time, m);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checked++;
		if (got !== exp)
			fail(m);
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// entered just after a rising edge; each channel dropped at the edge it is taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		int n;
		n = 0;
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		bready <= 1'b1;
		do
		begin
			@(posedge core_clk);
			n++;
			if (awvalid && awready === 1'b1)
				awvalid <= 1'b0;
			if (wvalid && wready === 1'b1)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 100);
		bready <= 1'b0;
		if (n >= 100)
			fail("write hang");
		chk(bresp, er, "write response");
		// one idle edge so a following call never re-drives bready in this step
		@(posedge core_clk);
	endtask

	task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		n = 0;
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do
		begin
			@(posedge core_clk);
			n++;
			if (arvalid && arready === 1'b1)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 100);
		rready <= 1'b0;
		if (n >= 100)
			fail("read hang");
		chk(rdata, ed, "read data");
		chk(rresp, er, "read response");
		@(posedge core_clk);
	endtask

	// independent reference verdict from the entry settings
	function automatic logic model(input logic [31:0] c, input logic [15:0] iv, input logic [7:0] nh,
		input logic [31:0] s, input logic [7:0] hp, input logic [15:0] ic, input logic [2:0] ut);
		logic ok;
		ok = ut[2];
		case (c[2:0])
			3'h0: ok = ok;
			3'h1: ok = ok & (nh == c[15:8]);
			3'h2: ok = ok & (nh == 8'h3A) & (!c[24] | (ic[7:0] == iv[7:0])) & (!c[25] | (ic[15:8] == iv[15:8]));
			3'h3: ok = ok & (nh == 8'h11) & ut[1];
			3'h4: ok = ok & (nh == 8'h06) & ut[0];
			default: ok = 1'b0;
		endcase
		if (c[16])
			ok = ok & ((s & sm) == (sa & sm));
		if (c[21:20] == 2'h1)
			ok = ok & (hp == 8'h00);
		else if (c[21:20] == 2'h2)
			ok = ok & (hp != 8'h00);
		else if (c[21:20] == 2'h3)
			ok = 1'b0;
		return ok;
	endfunction

	task automatic set_src(input logic [31:0] a, input logic [31:0] m);
		sa = a;
		sm = m;
		axw(ADDR_SRC_ADDR, a, 4'hF, RESP_OKAY);
		axw(ADDR_SRC_MASK, m, 4'hF, RESP_OKAY);
	endtask

	// ut packs ipv6, udp conditions, tcp conditions; ic packs code, type
	task automatic run(input logic [31:0] c, input logic [15:0] iv, input logic [7:0] nh,
		input logic [31:0] s, input logic [7:0] hp, input logic [15:0] ic, input logic [2:0] ut);
		logic e;
		e = model(c, iv, nh, s, hp, ic, ut);
		axw(ADDR_CFG, c, 4'hF, RESP_OKAY);
		axw(ADDR_ICMP_VAL, {16'h0000, iv}, 4'hF, RESP_OKAY);
		parser_u.send(ut[2], nh, s, hp, ic[7:0], ic[15:8], ut[1], ut[0]);
		@(posedge core_clk);
		chk(hit_valid, 1'b1, "no verdict strobe");
		chk(hit, e, "wrong verdict");
		if (e)
			hits++;
		last_hit = e;
	endtask

	initial
	begin
		repeat (20000) @(posedge core_clk);
		fail("watchdog expired");
		summarize();
	end

	initial
	begin
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		axr(ADDR_CFG, CFG_RESET, RESP_OKAY);
		axr(ADDR_ICMP_VAL, ICMP_RESET, RESP_OKAY);
		axr(ADDR_SRC_ADDR, SRC_ADDR_RESET, RESP_OKAY);
		axr(ADDR_SRC_MASK, SRC_MASK_RESET, RESP_OKAY);
		axr(ADDR_HIT_COUNT, 32'h00000000, RESP_OKAY);
		axr(8'h18, 32'h00000000, RESP_SLVERR);
		axw(ADDR_STATUS, 32'h00000001, 4'hF, RESP_SLVERR);
		axw(8'h02, 32'h00000001, 4'hF, RESP_SLVERR);
		axw(ADDR_CFG, FULL_WMASK, 4'hF, RESP_OKAY);
		axr(ADDR_CFG, CFG_WMASK, RESP_OKAY);
		axw(ADDR_SRC_ADDR, 32'hAABBCCDD, 4'h5, RESP_OKAY);
		axr(ADDR_SRC_ADDR, 32'h00BB00DD, RESP_OKAY);
		$display("test done: registers");
		run(32'h00000000, 16'h0000, 8'h99, 32'h00000000, 8'h05, 16'h0000, 3'h4);
		run(32'h00000000, 16'h0000, 8'h99, 32'h00000000, 8'h05, 16'h0000, 3'h0);
		run(32'h0000FF01, 16'h0000, 8'hFF, 32'h00000000, 8'h05, 16'h0000, 3'h4);
		run(32'h0000FF01, 16'h0000, 8'hFE, 32'h00000000, 8'h05, 16'h0000, 3'h4);
		run(32'h00000001, 16'h0000, 8'h00, 32'h00000000, 8'h05, 16'h0000, 3'h4);
		run(32'h00000002, 16'h0000, 8'h3A, 32'h00000000, 8'h05, 16'h1234, 3'h4);
		run(32'h00000002, 16'h0000, 8'h11, 32'h00000000, 8'h05, 16'h0000, 3'h7);
		run(32'h01000002, 16'h0087, 8'h3A, 32'h00000000, 8'h05, 16'h5587, 3'h4);
		run(32'h01000002, 16'h0087, 8'h3A, 32'h00000000, 8'h05, 16'h0088, 3'h4);
		run(32'h02000002, 16'hFF00, 8'h3A, 32'h00000000, 8'h05, 16'hFF66, 3'h4);
		run(32'h02000002, 16'hFF00, 8'h3A, 32'h00000000, 8'h05, 16'hFE00, 3'h4);
		run(32'h00000003, 16'h0000, 8'h11, 32'h00000000, 8'h05, 16'h0000, 3'h6);
		run(32'h00000003, 16'h0000, 8'h11, 32'h00000000, 8'h05, 16'h0000, 3'h5);
		run(32'h00000003, 16'h0000, 8'h06, 32'h00000000, 8'h05, 16'h0000, 3'h7);
		run(32'h00000004, 16'h0000, 8'h06, 32'h00000000, 8'h05, 16'h0000, 3'h5);
		run(32'h00000004, 16'h0000, 8'h06, 32'h00000000, 8'h05, 16'h0000, 3'h6);
		run(32'h00000004, 16'h0000, 8'h11, 32'h00000000, 8'h05, 16'h0000, 3'h7);
		set_src(32'h12345678, 32'hFFFFFFFF);
		run(32'h00000000, 16'h0000, 8'h99, 32'hDEADBEEF, 8'h05, 16'h0000, 3'h4);
		set_src(32'h00000003, 32'hFFFFFFFE);
		run(32'h00010000, 16'h0000, 8'h99, 32'h00000002, 8'h05, 16'h0000, 3'h4);
		run(32'h00010000, 16'h0000, 8'h99, 32'h00000001, 8'h05, 16'h0000, 3'h4);
		run(32'h00010000, 16'h0000, 8'h99, 32'h80000003, 8'h05, 16'h0000, 3'h4);
		set_src(32'hFFFF0003, 32'h0000FFFF);
		run(32'h00010000, 16'h0000, 8'h99, 32'h12340003, 8'h05, 16'h0000, 3'h4);
		run(32'h00100000, 16'h0000, 8'h99, 32'h00000000, 8'h00, 16'h0000, 3'h4);
		run(32'h00100000, 16'h0000, 8'h99, 32'h00000000, 8'h01, 16'h0000, 3'h4);
		run(32'h00200000, 16'h0000, 8'h99, 32'h00000000, 8'h01, 16'h0000, 3'h4);
		run(32'h00200000, 16'h0000, 8'h99, 32'h00000000, 8'hFF, 16'h0000, 3'h4);
		run(32'h00000000, 16'h0000, 8'h99, 32'h00000000, 8'h00, 16'h0000, 3'h4);
		run(32'h00000000, 16'h0000, 8'h99, 32'h00000000, 8'hFF, 16'h0000, 3'h4);
		run(32'h00000005, 16'h0000, 8'h99, 32'h00000000, 8'h05, 16'h0000, 3'h4);
		run(32'h00300000, 16'h0000, 8'h99, 32'h00000000, 8'h05, 16'h0000, 3'h4);
		run(32'h03110002, 16'h0201, 8'h3A, 32'h00000003, 8'h00, 16'h0201, 3'h4);
		run(32'h03110002, 16'h0201, 8'h3A, 32'h00000003, 8'h00, 16'h0301, 3'h4);
		run(32'h03110002, 16'h0201, 8'h3A, 32'h00000003, 8'h01, 16'h0201, 3'h4);
		run(32'h03110002, 16'h0201, 8'h3A, 32'h00000013, 8'h00, 16'h0201, 3'h4);
		$display("test done: matching");
		// frozen clock enable: frame ignored, bus refused
		ce <= 1'b0;
		parser_u.send(1'b1, 8'h3A, 32'h00000003, 8'h00, 8'h01, 8'h02, 1'b0, 1'b0);
		chk(awready, 1'b0, "ready while disabled");
		@(posedge core_clk);
		chk(hit_valid, 1'b0, "frame taken while disabled");
		ce <= 1'b1;
		@(posedge core_clk);
		axr(ADDR_STATUS, {31'h00000000, last_hit}, RESP_OKAY);
		axr(ADDR_HIT_COUNT, hits, RESP_OKAY);
		$display("test done: enable and counters");
		summarize();
	end
endmodule
`default_nettype wire
